/* File: design/fdm_pkg.sv */
// Constants, modes and register layout of the fault detection manager.
// Assumes a 200 MHz core clock and a host port with one-cycle read data.
package fdm_pkg;
	typedef enum logic [4:0] {
		FDM_RESET   = 5'b0_0001,
		FDM_NREQ    = 5'b0_0010,
		FDM_NORMAL  = 5'b0_0100,
		FDM_STOP    = 5'b0_1000,
		FDM_SLEEP   = 5'b1_0000
	} fdm_mode_t;

	localparam logic [3:0] FDM_ADDR_SUPPLY  = 4'h0;
	localparam logic [3:0] FDM_ADDR_BUS     = 4'h1;
	localparam logic [3:0] FDM_ADDR_DRIVER  = 4'h2;
	localparam logic [3:0] FDM_ADDR_WDOG    = 4'h3;
	localparam logic [3:0] FDM_ADDR_ISRC    = 4'h4;
	localparam logic [3:0] FDM_ADDR_MODE    = 4'h5;
	localparam logic [3:0] FDM_ADDR_HSCTL   = 4'h6;
	localparam logic [3:0] FDM_ADDR_MASK    = 4'h7;

	localparam int FDM_BIT_BATTERY_FAIL_FLAG = 0;
	localparam int FDM_BIT_REGULATOR_OVERTEMP_WARN_FLAG   = 1;
	localparam int FDM_BIT_UV      = 2;
	localparam int FDM_BIT_OV      = 3;
	localparam int FDM_BIT_BUS_DRIVER_OVERTEMP_FLAG   = 1;
	localparam int FDM_BIT_STUCK_DOMINANT_FLAG   = 2;
	localparam int FDM_BIT_RECEIVE_SHORT_FLAG = 3;
	localparam int FDM_BIT_DRIVER1_CURRENT_LIMIT_FLAG   = 0;
	localparam int FDM_BIT_DRIVER1_OPEN_LOAD_FLAG   = 1;
	localparam int FDM_BIT_DRIVER2_CURRENT_LIMIT_FLAG   = 2;
	localparam int FDM_BIT_DRIVER2_OPEN_LOAD_FLAG   = 3;
	localparam int FDM_BIT_WATCHDOG_CONFIG_ERROR_FLAG   = 2;
	localparam int FDM_BIT_WATCHDOG_TIMEOUT_FLAG    = 3;
	localparam int FDM_BIT_HIGH_VOLTAGE_SHUTDOWN_ENABLE    = 4;
	localparam int FDM_BIT_GONORM  = 3;
	localparam int FDM_BIT_WDCLR   = 2;
	localparam int FDM_BIT_GOSTOP  = 1;
	localparam int FDM_BIT_GOSLEEP = 0;
	localparam int FDM_BIT_MSK_SUP = 0;
	localparam int FDM_BIT_MSK_BUS = 1;
	localparam int FDM_BIT_MSK_HS  = 2;

	localparam logic [3:0] FDM_CODE_SUPPLY = 4'h5;
	localparam logic [3:0] FDM_CODE_BUS    = 4'h4;
	localparam logic [3:0] FDM_CODE_HS     = 4'h2;
	localparam logic [3:0] FDM_CODE_NONE   = 4'h0;
	localparam logic [7:0] FDM_MASK_RST    = 8'h07;

	localparam int FDM_CLK_KHZ     = 200_000;
	localparam int FDM_STUCK_DOMINANT_FLAG_MS    = 1000;
	localparam int FDM_NREQ_MS     = 150;
	localparam int FDM_RSTLOW_US   = 1000;
	localparam int FDM_STUCK_DOMINANT_FLAG_CYC   = FDM_STUCK_DOMINANT_FLAG_MS * FDM_CLK_KHZ;
	localparam int FDM_NREQ_CYC    = FDM_NREQ_MS * FDM_CLK_KHZ;
	localparam int FDM_RSTLOW_CYC  = (FDM_RSTLOW_US * FDM_CLK_KHZ) / 1000;
	localparam int FDM_DEGLITCH    = 4;
endpackage

/* File: design/fdm_core.sv */
// Fault detection manager: flags, interrupt, reset, shutdowns.
// Assumes analog indications arrive asynchronous; host port on core_clk.
`timescale 1ns/10ps
`default_nettype none
module fdm_core
	import fdm_pkg::*;
#(
	parameter int STUCK_DOMINANT_FLAG_CYC  = FDM_STUCK_DOMINANT_FLAG_CYC,
	parameter int NREQ_CYC   = FDM_NREQ_CYC,
	parameter int RSTLOW_CYC = FDM_RSTLOW_CYC
) (
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic [3:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr_en,
	input  wire logic       rd_en,
	output logic      [7:0] rdata,
	input  wire logic       battery_fail_in,
	input  wire logic       supply_ov_in,
	input  wire logic       supply_uv_in,
	input  wire logic       reg_uv_in,
	input  wire logic       reg_warn_in,
	input  wire logic       reg_hot_in,
	input  wire logic       rx_short_in,
	input  wire logic       txd_in,
	input  wire logic       bus_hot_in,
	input  wire logic       hs_hot_in,
	input  wire logic       hs1_cl_in,
	input  wire logic       hs1_ol_in,
	input  wire logic       hs2_cl_in,
	input  wire logic       hs2_ol_in,
	input  wire logic       wd_expired_in,
	input  wire logic       wd_early_clr_in,
	input  wire logic       watchdog_config_pin_float,
	output logic            irq_n,
	output logic            rst_out_n,
	output logic            bus_tx_en,
	output logic            hs1_en,
	output logic            hs2_en,
	output logic            reg_en,
	output logic      [4:0] mode
);
	localparam int NIN = 17;
	localparam int TXD_POS = 7;
	localparam int HS1_CTL_BIT = 0;
	localparam int HS2_CTL_BIT = 1;
	// Transmit pin idles high; a low reset level would fake a dominant start
	localparam logic [NIN-1:0] IN_IDLE = NIN'(1) << TXD_POS;

	// ------------------------------------------------------------
	// Input synchronisers and deglitch
	// ------------------------------------------------------------
	logic [NIN-1:0] raw;
	logic [NIN-1:0] s1_reg;
	logic [NIN-1:0] s2_reg;
	logic [NIN-1:0] clean_reg;
	logic [2:0]     dg_reg [NIN];

	assign raw = {watchdog_config_pin_float, wd_early_clr_in, wd_expired_in, hs2_ol_in,
		hs2_cl_in, hs1_ol_in, hs1_cl_in, hs_hot_in, bus_hot_in, txd_in, rx_short_in,
		reg_hot_in, reg_warn_in, reg_uv_in, supply_uv_in, supply_ov_in, battery_fail_in};

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s1_reg <= IN_IDLE;
			s2_reg <= IN_IDLE;
		end else begin
			s1_reg <= raw;
			s2_reg <= s1_reg;
		end
	end

	// A level must hold FDM_DEGLITCH cycles before it is believed
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			clean_reg <= IN_IDLE;
			for (int i = 0; i < NIN; i++) dg_reg[i] <= '0;
		end else begin
			for (int i = 0; i < NIN; i++) begin
				if (s2_reg[i] == clean_reg[i]) begin
					dg_reg[i] <= '0;
				end else if (dg_reg[i] == 3'(FDM_DEGLITCH - 1)) begin
					dg_reg[i]    <= '0;
					clean_reg[i] <= s2_reg[i];
				end else begin
					dg_reg[i] <= dg_reg[i] + 3'd1;
				end
			end
		end
	end

	logic batf, ov, uv, vdduv, vddwarn, vddhot, rxs, txd, bushot, hshot;
	logic h1cl, h1ol, h2cl, h2ol, wdexp, wdearly, wdfloat;
	assign {wdfloat, wdearly, wdexp, h2ol, h2cl, h1ol, h1cl, hshot, bushot, txd, rxs,
		vddhot, vddwarn, vdduv, uv, ov, batf} = clean_reg;

	// ------------------------------------------------------------
	// Host registers
	// ------------------------------------------------------------
	logic [7:0] mode_ctl_reg;
	logic [7:0] mask_reg;
	logic       hsctl_wr;
	logic       bus_rd;
	logic       nreq_cmd;
	logic       stop_cmd;
	logic       sleep_cmd;

	assign hsctl_wr  = wr_en && addr == FDM_ADDR_HSCTL;
	assign bus_rd    = rd_en && addr == FDM_ADDR_BUS;
	assign nreq_cmd  = wr_en && addr == FDM_ADDR_MODE && wdata[FDM_BIT_GONORM];
	assign stop_cmd  = wr_en && addr == FDM_ADDR_MODE && wdata[FDM_BIT_GOSTOP];
	assign sleep_cmd = wr_en && addr == FDM_ADDR_MODE && wdata[FDM_BIT_GOSLEEP];

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mode_ctl_reg <= '0;
			mask_reg     <= FDM_MASK_RST;
		end else begin
			if (wr_en && addr == FDM_ADDR_MODE) mode_ctl_reg <= wdata;
			if (wr_en && addr == FDM_ADDR_MASK) mask_reg <= wdata;
		end
	end

	// ------------------------------------------------------------
	// Mode machine and reset output
	// ------------------------------------------------------------
	fdm_mode_t  mode_reg;
	fdm_mode_t  mode_next;
	logic       rst_src;
	logic [31:0] nreq_cnt_reg;
	logic [31:0] rstlow_cnt_reg;
	logic       after_hot_reg;
	logic       in_norm;
	logic       in_nreq;
	logic       irq_mode;
	logic [3:0] supply_flags_reg;

	assign in_norm  = mode_reg == FDM_NORMAL;
	assign in_nreq  = mode_reg == FDM_NREQ;
	assign irq_mode = in_norm || in_nreq || mode_reg == FDM_STOP;

	assign rst_src = (vdduv && mode_reg != FDM_SLEEP)
		|| (vddhot && mode_reg != FDM_SLEEP && mode_reg != FDM_STOP)
		|| (in_nreq && nreq_cnt_reg == 32'(NREQ_CYC - 1))
		|| (in_norm && (wdexp || wdearly));

	always_comb begin
		mode_next = mode_reg;
		unique case (mode_reg)
			FDM_RESET: begin
				if (after_hot_reg) mode_next = FDM_SLEEP;
				else if (vdduv && !supply_flags_reg[FDM_BIT_UV]) mode_next = FDM_SLEEP;
				else if (!rst_src && rstlow_cnt_reg == 32'(RSTLOW_CYC - 1)) mode_next = FDM_NREQ;
			end
			FDM_NREQ: begin
				if (rst_src) mode_next = FDM_RESET;
				else if (nreq_cmd) mode_next = FDM_NORMAL;
			end
			FDM_NORMAL: begin
				if (rst_src) mode_next = FDM_RESET;
				else if (sleep_cmd) mode_next = FDM_SLEEP;
				else if (stop_cmd) mode_next = FDM_STOP;
			end
			FDM_STOP: begin
				if (rst_src) mode_next = FDM_RESET;
				else if (nreq_cmd) mode_next = FDM_NREQ;
			end
			FDM_SLEEP: begin
				// Wake-up is a GONORM write, which re-enters reset first
				if (nreq_cmd) mode_next = FDM_RESET;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) mode_reg <= FDM_RESET;
		else mode_reg <= mode_next;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) after_hot_reg <= 1'b0;
		else if (vddhot && mode_reg != FDM_SLEEP && mode_reg != FDM_STOP) after_hot_reg <= 1'b1;
		else if (mode_reg == FDM_SLEEP) after_hot_reg <= 1'b0;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) nreq_cnt_reg <= '0;
		else if (!in_nreq) nreq_cnt_reg <= '0;
		else nreq_cnt_reg <= nreq_cnt_reg + 32'd1;
	end

	// Counts only once the source is gone, so the low time is a minimum
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) rstlow_cnt_reg <= '0;
		else if (rst_src || mode_reg != FDM_RESET) rstlow_cnt_reg <= '0;
		else if (rstlow_cnt_reg != 32'(RSTLOW_CYC - 1)) rstlow_cnt_reg <= rstlow_cnt_reg + 32'd1;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rst_out_n <= 1'b0;
			reg_en    <= 1'b1;
			mode      <= FDM_RESET;
		end else begin
			rst_out_n <= mode_next != FDM_RESET && mode_next != FDM_SLEEP;
			reg_en    <= mode_next != FDM_SLEEP && !(vddhot && !after_hot_reg);
			mode      <= mode_next;
		end
	end

	// ------------------------------------------------------------
	// Status flags
	// ------------------------------------------------------------
	logic [3:0]  bus_flags_reg;
	logic [3:0]  hs_flags_reg;
	logic [3:0]  wd_flags_reg;
	logic [31:0] txlow_cnt_reg;
	logic        stuck_dominant_flag_hit;

	assign stuck_dominant_flag_hit = !txd && txlow_cnt_reg == 32'(STUCK_DOMINANT_FLAG_CYC - 1);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) txlow_cnt_reg <= '0;
		else if (txd) txlow_cnt_reg <= '0;
		else if (!stuck_dominant_flag_hit) txlow_cnt_reg <= txlow_cnt_reg + 32'd1;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) supply_flags_reg <= '0;
		else begin
			supply_flags_reg[FDM_BIT_BATTERY_FAIL_FLAG] <= batf;
			supply_flags_reg[FDM_BIT_REGULATOR_OVERTEMP_WARN_FLAG]   <= vddwarn && mode_reg != FDM_SLEEP
				&& mode_reg != FDM_STOP;
			supply_flags_reg[FDM_BIT_UV] <= uv && (in_norm || in_nreq);
			supply_flags_reg[FDM_BIT_OV] <= ov && (in_norm || in_nreq);
		end
	end

	// Set wins over a clearing read in the same cycle
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) bus_flags_reg <= '0;
		else begin
			bus_flags_reg[0] <= 1'b0;
			bus_flags_reg[FDM_BIT_BUS_DRIVER_OVERTEMP_FLAG] <= bushot;
			if (stuck_dominant_flag_hit) bus_flags_reg[FDM_BIT_STUCK_DOMINANT_FLAG] <= 1'b1;
			else if (bus_rd && txd) bus_flags_reg[FDM_BIT_STUCK_DOMINANT_FLAG] <= 1'b0;
			if (rxs) bus_flags_reg[FDM_BIT_RECEIVE_SHORT_FLAG] <= 1'b1;
			else if (bus_rd) bus_flags_reg[FDM_BIT_RECEIVE_SHORT_FLAG] <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) hs_flags_reg <= '0;
		else if (hshot) hs_flags_reg <= '1;
		else if (in_norm || in_nreq) hs_flags_reg <= {h2ol, h2cl, h1ol, h1cl};
		else hs_flags_reg <= '0;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) wd_flags_reg <= '0;
		else begin
			wd_flags_reg[FDM_BIT_WATCHDOG_CONFIG_ERROR_FLAG] <= wdfloat;
			if (in_norm && (wdexp || wdearly)) wd_flags_reg[FDM_BIT_WATCHDOG_TIMEOUT_FLAG] <= 1'b1;
			else if (rd_en && addr == FDM_ADDR_WDOG) wd_flags_reg[FDM_BIT_WATCHDOG_TIMEOUT_FLAG] <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Shutdowns
	// ------------------------------------------------------------
	logic bus_fault;
	logic hs_off_reg;
	logic hs_trip;

	assign bus_fault = rxs || bushot || stuck_dominant_flag_hit;
	assign hs_trip   = hshot || (in_norm && ov && mode_ctl_reg[FDM_BIT_HIGH_VOLTAGE_SHUTDOWN_ENABLE]);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) bus_tx_en <= 1'b1;
		else if (bus_fault) bus_tx_en <= 1'b0;
		else if (!bus_tx_en && txd) bus_tx_en <= 1'b1;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) hs_off_reg <= 1'b0;
		else if (hs_trip) hs_off_reg <= 1'b1;
		else if (hsctl_wr) hs_off_reg <= 1'b0;
	end

	// Current limiting keeps the driver on; only trips turn it off
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			hs1_en <= 1'b0;
			hs2_en <= 1'b0;
		end else if (hs_trip || (hs_off_reg && !hsctl_wr)) begin
			hs1_en <= 1'b0;
			hs2_en <= 1'b0;
		end else if (hsctl_wr) begin
			hs1_en <= wdata[HS1_CTL_BIT];
			hs2_en <= wdata[HS2_CTL_BIT];
		end
	end

	// ------------------------------------------------------------
	// Interrupt source and output
	// ------------------------------------------------------------
	logic [3:0] isrc_reg;
	logic       sup_evt, bus_evt, hs_evt;

	assign sup_evt = (supply_flags_reg[FDM_BIT_OV] || supply_flags_reg[FDM_BIT_UV]
		|| supply_flags_reg[FDM_BIT_REGULATOR_OVERTEMP_WARN_FLAG]) && mask_reg[FDM_BIT_MSK_SUP];
	assign bus_evt = (bus_flags_reg[FDM_BIT_STUCK_DOMINANT_FLAG] || bus_flags_reg[FDM_BIT_BUS_DRIVER_OVERTEMP_FLAG]
		|| bus_flags_reg[FDM_BIT_RECEIVE_SHORT_FLAG]) && mask_reg[FDM_BIT_MSK_BUS];
	assign hs_evt  = hshot && mask_reg[FDM_BIT_MSK_HS];

	// Highest code wins when several sources are pending
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) isrc_reg <= FDM_CODE_NONE;
		else if (!irq_mode) isrc_reg <= isrc_reg;
		else if (sup_evt) isrc_reg <= FDM_CODE_SUPPLY;
		else if (bus_evt) isrc_reg <= FDM_CODE_BUS;
		else if (hs_evt) isrc_reg <= FDM_CODE_HS;
		else if (rd_en && addr == FDM_ADDR_ISRC) isrc_reg <= FDM_CODE_NONE;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) irq_n <= 1'b1;
		else irq_n <= !(irq_mode && (sup_evt || bus_evt || hs_evt));
	end

	// ------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) rdata <= '0;
		else if (!rd_en) rdata <= '0;
		else begin
			unique case (addr)
				FDM_ADDR_SUPPLY: rdata <= {4'h0, supply_flags_reg};
				FDM_ADDR_BUS:    rdata <= {4'h0, bus_flags_reg};
				FDM_ADDR_DRIVER: rdata <= {4'h0, hs_flags_reg};
				FDM_ADDR_WDOG:   rdata <= {4'h0, wd_flags_reg};
				FDM_ADDR_ISRC:   rdata <= {4'h0, isrc_reg};
				FDM_ADDR_MODE:   rdata <= mode_ctl_reg;
				FDM_ADDR_HSCTL:  rdata <= {6'h00, hs2_en, hs1_en};
				FDM_ADDR_MASK:   rdata <= mask_reg;
				default:         rdata <= '0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	masked_irq_a: assert property (@(posedge core_clk) disable iff (rst)
		(!mask_reg[FDM_BIT_MSK_SUP] && !bus_evt && !hs_evt) |=> irq_n)
		else $error("masked sources drove irq");
	irq_mode_a: assert property (@(posedge core_clk) disable iff (rst)
		(mode_reg == FDM_SLEEP) |=> irq_n)
		else $error("irq in sleep");
	ov_flag_a: assert property (@(posedge core_clk) disable iff (rst)
		(ov && in_norm) |=> supply_flags_reg[FDM_BIT_OV])
		else $error("overvoltage flag missing");
	bus_off_a: assert property (@(posedge core_clk) disable iff (rst)
		rxs |=> !bus_tx_en && bus_flags_reg[FDM_BIT_RECEIVE_SHORT_FLAG])
		else $error("rx short not handled");
	tx_back_a: assert property (@(posedge core_clk) disable iff (rst)
		(!bus_tx_en && (!txd || rxs || bushot)) |=> !bus_tx_en)
		else $error("tx re-enabled with txd low");
	hs_hot_a: assert property (@(posedge core_clk) disable iff (rst)
		hshot |=> (hs_flags_reg == 4'hf) && !hs1_en && !hs2_en)
		else $error("hs overtemp not handled");
	hs_stay_a: assert property (@(posedge core_clk) disable iff (rst)
		(hs_off_reg && !hsctl_wr) |=> !hs1_en && !hs2_en)
		else $error("hs back without write");
	rst_low_a: assert property (@(posedge core_clk) disable iff (rst)
		$rose(rst_out_n) |-> $past(rstlow_cnt_reg) == 32'(RSTLOW_CYC - 1))
		else $error("reset released early");
	watchdog_timeout_flag_a: assert property (@(posedge core_clk) disable iff (rst)
		(in_norm && wdexp) |=> wd_flags_reg[FDM_BIT_WATCHDOG_TIMEOUT_FLAG] && !rst_out_n)
		else $error("watchdog timeout not handled");
	batf_a: assert property (@(posedge core_clk) disable iff (rst)
		batf |=> supply_flags_reg[FDM_BIT_BATTERY_FAIL_FLAG])
		else $error("battery fail flag missing");
endmodule
`default_nettype wire

/* File: sim/fdm_host.sv */
// Host controller model that drives the register port of the block.
// Assumes the bench seeds $urandom and calls tasks just after a clock edge.
`timescale 1ns/10ps
`default_nettype none
module fdm_host
	import fdm_pkg::*;
(
	output logic [3:0] addr,
	output logic [7:0] wdata,
	output logic       wr_en,
	output logic       rd_en,
	input  wire logic  core_clk
);
	// ----------
	// Bus cycles
	// ----------
	// Called once by the bench, so one process owns every host signal
	task automatic idle();
		addr <= 4'h0;
		wdata <= 8'h00;
		wr_en <= 1'b0;
		rd_en <= 1'b0;
	endtask
	// Random idle gap, so the host is sometimes prompt, sometimes slow
	task automatic access(input logic w, input logic [3:0] a, input logic [7:0] d);
		repeat (1 + ($urandom % 3)) @(posedge core_clk);
		addr <= a;
		wdata <= d;
		wr_en <= w;
		rd_en <= !w;
		@(posedge core_clk);
		wr_en <= 1'b0;
		rd_en <= 1'b0;
		// Scrambled so stale values never pass for valid ones
		addr <= ~a;
		wdata <= ~d;
	endtask
	task automatic go_normal();
		access(1'b1, FDM_ADDR_MODE, 8'h18);
	endtask
	task automatic restore_drivers();
		access(1'b1, FDM_ADDR_HSCTL, 8'h03);
	endtask
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
// Self-checking bench for the fault detection manager.
// Assumes shortened timing parameters; fault inputs are plain levels.
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import fdm_pkg::*;
;
	// ----------
	// Setup
	// ----------
	localparam int TXD_N  = 50;
	localparam int NREQ_N = 60;
	localparam int RSTL_N = 20;
	logic        core_clk, rst, txd, rd_q, wr_en, rd_en;
	logic        irq_n, rst_out_n, bus_tx_en, hs1_en, hs2_en, reg_en;
	logic [3:0]  addr, pat;
	logic [4:0]  mode;
	logic [7:0]  wdata, rdata;
	logic [15:0] flt;
	logic [7:0]  exp_q[$];
	int          fail_count, n_compared, n;

	fdm_core #(.STUCK_DOMINANT_FLAG_CYC(TXD_N), .NREQ_CYC(NREQ_N), .RSTLOW_CYC(RSTL_N)) dut_u (
		.core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .rdata(rdata), .battery_fail_in(flt[0]), .reg_warn_in(flt[1]),
		.supply_uv_in(flt[2]), .supply_ov_in(flt[3]), .reg_uv_in(flt[4]), .reg_hot_in(flt[5]),
		.bus_hot_in(flt[6]), .rx_short_in(flt[7]), .hs1_cl_in(flt[8]), .hs1_ol_in(flt[9]),
		.hs2_cl_in(flt[10]), .hs2_ol_in(flt[11]), .hs_hot_in(flt[12]), .txd_in(txd),
		.wd_expired_in(flt[13]), .wd_early_clr_in(flt[14]),
		.watchdog_config_pin_float(flt[15]), .irq_n(irq_n), .rst_out_n(rst_out_n),
		.bus_tx_en(bus_tx_en), .hs1_en(hs1_en), .hs2_en(hs2_en), .reg_en(reg_en), .mode(mode)
	);
	fdm_host host_u (.core_clk(core_clk), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en));

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	// ----------
	// Tasks
	// ----------
	task automatic report_and_stop();
		$display("compared %0d failed %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic tally(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_rd(input logic [7:0] e);
		tally("rdata", e, rdata);
	endtask
	task automatic chk_pin(input string nm, input logic e, input logic g);
		tally(nm, {7'h00, e}, {7'h00, g});
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge core_clk);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		host_u.access(1'b0, a, 8'h00);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		host_u.access(1'b1, a, d);
	endtask
	// Bounded wait on reset output (k=0) or mode (k=1)
	task automatic wait_for(input logic k, input logic [4:0] v, input int lim, output int c);
		c = 0;
		while ((k ? mode : {4'h0, rst_out_n}) !== v) begin
			if (c >= lim) begin
				fail_count++;
				$display("CHECK FAILED wait expected %h seen timeout", v);
				report_and_stop();
			end
			@(posedge core_clk);
			c++;
		end
	endtask
	task automatic restart();
		wait_for(1'b0, 5'h01, 300, n);
		chk_pin("rst_hold", 1'b1, n >= RSTL_N);
		wait_for(1'b1, FDM_NREQ, 20, n);
		host_u.go_normal();
		wait_for(1'b1, FDM_NORMAL, 20, n);
		host_u.restore_drivers();
	endtask

	// Read data stand only in the cycle after the strobe
	always @(posedge core_clk) begin
		rd_q <= rd_en;
		if (rd_q && exp_q.size() > 0) chk_rd(exp_q.pop_front());
	end

	// ----------
	// Sequence
	// ----------
	initial begin
		void'($urandom(69396));
		rst = 1'b1;
		txd = 1'b1;
		flt = 16'h0000;
		host_u.idle();
		fail_count = 0;
		n_compared = 0;
		cyc(3);
		chk_pin("irq_n", 1'b1, irq_n);
		chk_pin("rst_out_n", 1'b0, rst_out_n);
		cyc(2);
		rst <= 1'b0;
		restart();
		rd(FDM_ADDR_MASK, FDM_MASK_RST);
		rd(4'hF, 8'h00);
		wr(FDM_ADDR_SUPPLY, 8'hFF);
		rd(FDM_ADDR_SUPPLY, 8'h00);
		flt[0] <= 1'b1;
		cyc(14);
		rd(FDM_ADDR_SUPPLY, 8'h01);
		chk_pin("irq_n", 1'b1, irq_n);
		flt[0] <= 1'b0;
		cyc(14);
		rd(FDM_ADDR_SUPPLY, 8'h00);
		flt[3] <= 1'b1;
		cyc(2);
		flt[3] <= 1'b0;
		cyc(14);
		rd(FDM_ADDR_SUPPLY, 8'h00);
		for (int k = 1; k < 4; k++) begin
			flt[k] <= 1'b1;
			cyc(14);
			rd(FDM_ADDR_SUPPLY, 8'h01 << k);
			rd(FDM_ADDR_ISRC, {4'h0, FDM_CODE_SUPPLY});
			chk_pin("irq_n", 1'b0, irq_n);
			if (k == 3) chk_pin("hs_on", 1'b0, hs1_en | hs2_en);
			flt[k] <= 1'b0;
			cyc(14);
			rd(FDM_ADDR_SUPPLY, 8'h00);
			rd(FDM_ADDR_ISRC, {4'h0, FDM_CODE_SUPPLY});
			rd(FDM_ADDR_ISRC, 8'h00);
			cyc(3);
			chk_pin("irq_n", 1'b1, irq_n);
			if (k == 3) begin
				chk_pin("hs_on", 1'b0, hs1_en | hs2_en);
				host_u.restore_drivers();
				cyc(3);
				chk_pin("hs_on", 1'b1, hs1_en & hs2_en);
			end
		end
		wr(FDM_ADDR_MASK, 8'h06);
		flt[2] <= 1'b1;
		cyc(14);
		chk_pin("irq_n", 1'b1, irq_n);
		rd(FDM_ADDR_ISRC, 8'h00);
		rd(FDM_ADDR_SUPPLY, 8'h04);
		flt[2] <= 1'b0;
		cyc(14);
		wr(FDM_ADDR_MASK, 8'h07);
		flt[6] <= 1'b1;
		cyc(14);
		chk_pin("tx_en", 1'b0, bus_tx_en);
		rd(FDM_ADDR_BUS, 8'h02);
		rd(FDM_ADDR_ISRC, {4'h0, FDM_CODE_BUS});
		flt[6] <= 1'b0;
		cyc(14);
		chk_pin("tx_en", 1'b1, bus_tx_en);
		rd(FDM_ADDR_BUS, 8'h00);
		rd(FDM_ADDR_ISRC, {4'h0, FDM_CODE_BUS});
		rd(FDM_ADDR_ISRC, 8'h00);
		txd <= 1'b0;
		cyc(TXD_N - 30);
		txd <= 1'b1;
		cyc(14);
		chk_pin("tx_en", 1'b1, bus_tx_en);
		txd <= 1'b0;
		cyc(TXD_N + 20);
		chk_pin("tx_en", 1'b0, bus_tx_en);
		rd(FDM_ADDR_BUS, 8'h04);
		rd(FDM_ADDR_BUS, 8'h04);
		rd(FDM_ADDR_ISRC, {4'h0, FDM_CODE_BUS});
		txd <= 1'b1;
		cyc(14);
		chk_pin("tx_en", 1'b1, bus_tx_en);
		rd(FDM_ADDR_BUS, 8'h04);
		rd(FDM_ADDR_BUS, 8'h00);
		rd(FDM_ADDR_ISRC, {4'h0, FDM_CODE_BUS});
		rd(FDM_ADDR_ISRC, 8'h00);
		// Bus source masked here so the short leaves no pending event
		wr(FDM_ADDR_MASK, 8'h05);
		flt[7] <= 1'b1;
		cyc(14);
		chk_pin("tx_en", 1'b0, bus_tx_en);
		rd(FDM_ADDR_BUS, 8'h08);
		rd(FDM_ADDR_BUS, 8'h08);
		flt[7] <= 1'b0;
		cyc(14);
		chk_pin("tx_en", 1'b1, bus_tx_en);
		rd(FDM_ADDR_BUS, 8'h08);
		rd(FDM_ADDR_BUS, 8'h00);
		wr(FDM_ADDR_MASK, 8'h07);
		flt[12] <= 1'b1;
		cyc(14);
		chk_pin("hs_on", 1'b0, hs1_en | hs2_en);
		rd(FDM_ADDR_DRIVER, 8'h0F);
		rd(FDM_ADDR_ISRC, {4'h0, FDM_CODE_HS});
		flt[12] <= 1'b0;
		cyc(14);
		chk_pin("hs_on", 1'b0, hs1_en | hs2_en);
		rd(FDM_ADDR_ISRC, {4'h0, FDM_CODE_HS});
		rd(FDM_ADDR_ISRC, 8'h00);
		host_u.restore_drivers();
		cyc(3);
		chk_pin("hs_on", 1'b1, hs1_en & hs2_en);
		for (int k = 0; k < 5; k++) begin
			pat = (k < 4) ? (4'h1 << k) : 4'($urandom);
			flt[11:8] <= pat;
			cyc(14);
			rd(FDM_ADDR_DRIVER, {4'h0, pat});
			chk_pin("irq_n", 1'b1, irq_n);
			chk_pin("hs_on", 1'b1, hs1_en & hs2_en);
		end
		flt[15:8] <= 8'h80;
		cyc(14);
		rd(FDM_ADDR_WDOG, 8'h04);
		flt[15] <= 1'b0;
		cyc(14);
		rd(FDM_ADDR_WDOG, 8'h00);
		for (int k = 13; k < 15; k++) begin
			flt[k] <= 1'b1;
			cyc(8);
			flt[k] <= 1'b0;
			wait_for(1'b0, 5'h00, 20, n);
			restart();
			rd(FDM_ADDR_WDOG, 8'h08);
			rd(FDM_ADDR_WDOG, 8'h00);
		end
		wr(FDM_ADDR_MODE, 8'h12);
		wait_for(1'b1, FDM_STOP, 20, n);
		flt[12] <= 1'b1;
		cyc(14);
		chk_pin("irq_n", 1'b0, irq_n);
		rd(FDM_ADDR_ISRC, {4'h0, FDM_CODE_HS});
		flt[12] <= 1'b0;
		cyc(14);
		rd(FDM_ADDR_ISRC, {4'h0, FDM_CODE_HS});
		rd(FDM_ADDR_ISRC, 8'h00);
		wr(FDM_ADDR_MODE, 8'h08);
		wait_for(1'b1, FDM_NREQ, 20, n);
		host_u.go_normal();
		wait_for(1'b1, FDM_NORMAL, 20, n);
		host_u.restore_drivers();
		wr(FDM_ADDR_MODE, 8'h11);
		wait_for(1'b1, FDM_SLEEP, 20, n);
		wr(FDM_ADDR_MODE, 8'h08);
		restart();
		flt[4] <= 1'b1;
		wait_for(1'b0, 5'h00, 20, n);
		wait_for(1'b1, FDM_SLEEP, 60, n);
		flt[4] <= 1'b0;
		cyc(14);
		wr(FDM_ADDR_MODE, 8'h08);
		wait_for(1'b1, FDM_RESET, 20, n);
		wait_for(1'b1, FDM_NREQ, 300, n);
		wait_for(1'b0, 5'h00, 200, n);
		chk_pin("nreq_time", 1'b1, n >= NREQ_N - 3 && n <= NREQ_N + 5);
		restart();
		flt[5] <= 1'b1;
		wait_for(1'b0, 5'h00, 20, n);
		cyc(2);
		chk_pin("reg_en", 1'b0, reg_en);
		wait_for(1'b1, FDM_SLEEP, 300, n);
		flt <= flt | 16'h1004;
		cyc(14);
		chk_pin("irq_n", 1'b1, irq_n);
		cyc(3);
		report_and_stop();
	end
endmodule
`default_nettype wire
